// ---- fsw_host_model.sv ----
// Host-side model: serial frames, fault events and status word writes
`timescale 1ns/1ns
module fsw_host_model #(
  parameter logic [7:0] REQ_SCLK = 8'h20
) (
  // Clock
  input wire logic clk_sys,
  // Frame side
  output logic frame_start,
  output logic frame_end,
  output logic [7:0] sclk_count,
  output logic [7:0] sclk_required,
  output fsw_pkg::fsw_frame_evt_t frame_evt,
  // Register write
  output fsw_pkg::fsw_write_t host_wr
);
  initial begin
    frame_start = 1'b0;
    frame_end = 1'b0;
    sclk_count = ~REQ_SCLK;
    sclk_required = REQ_SCLK;
    frame_evt = '0;
    host_wr = '0;
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  // Start, one event cycle, end with the given clock count
  task automatic frame(input fsw_pkg::fsw_frame_evt_t evt, input logic [7:0] cnt);
    tick();
    frame_start = 1'b1;
    tick();
    frame_start = 1'b0;
    frame_evt = evt;
    tick();
    frame_evt = '0;
    frame_end = 1'b1;
    sclk_count = cnt;
    tick();
    frame_end = 1'b0;
    // Count outside frame_end must not matter
    sclk_count = ~cnt;
  endtask
  task automatic write_word(input logic [15:0] d);
    tick();
    host_wr = '{en: 1'b1, data: d};
    tick();
    host_wr = '{en: 1'b0, data: ~d};
  endtask
endmodule

// ---- fsw_pkg.sv ----
// Constants and carrier types for the upper status word fault summary block
// How it works
// - Bit 15 reads 0 after reset; host writing 1 returns it to 1.
// - Bit 14 is 0 while any unmasked power status flag is set.
// - Bit 13 is 0 while any unmasked clock status flag is set.
// - Bit 12 is 0 while any unmasked logic status flag is set.
// - Bit 11 is 0 while any unmasked overcurrent flag is set.
// - Writing 1 restores a summary bit only once its unmasked sources are clear.
// - Bit 10 is 0 when the previous frame had a checksum fault.
// - Bit 9 is 0 when the previous frame had a timeout fault.
// - Bit 8 is 0 when the previous frame had too few or too many clocks.
// - Bit 7 is 0 in the frame after an access to address FFh or above.
// - Per-frame bits 10 to 7 return to 1 at the next frame start after a fault-free frame.
// - After reset bits 14 to 7 read 1 and bit 15 reads 0.
package fsw_pkg;

  // ==========================================================
  // Field positions
  localparam int RESTART_BIT = 15;
  localparam int POWER_BIT = 14;
  localparam int NUM_SOURCES = 4;
  localparam int CHECKSUM_BIT = 10;
  localparam int TIMEOUT_BIT = 9;
  localparam int SCLK_COUNT_BIT = 8;
  localparam int BAD_ADDR_BIT = 7;

  // ==========================================================
  // Reset value of bits 15:7, low bits belong to other blocks and read 0
  localparam logic [15:0] STATUS_RESET = 16'h7f80;

  // Lowest address that counts as invalid
  localparam logic [7:0] FIRST_BAD_ADDR = 8'hff;

  // ==========================================================
  // Fault events reported by the serial frame logic during a frame
  typedef struct packed {
    logic checksum;
    logic timeout;
    logic access;
    logic [7:0] access_addr;
  } fsw_frame_evt_t;

  // Host write into the status word
  typedef struct packed {
    logic en;
    logic [15:0] data;
  } fsw_write_t;

endpackage

// ---- fsw_status_word.sv ----
// Upper status word: restart flag, four fault summaries, four per-frame faults
`timescale 1ns/1ns
module fsw_status_word #(
  parameter int SRC_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fault source groups: power, clock, logic, overcurrent
  input wire logic [fsw_pkg::NUM_SOURCES-1:0][SRC_W-1:0] src_flags,
  input wire logic [fsw_pkg::NUM_SOURCES-1:0][SRC_W-1:0] src_mask,
  // Serial frame logic
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic [7:0] sclk_count,
  input wire logic [7:0] sclk_required,
  input wire fsw_pkg::fsw_frame_evt_t frame_evt,
  // Host register write
  input wire fsw_pkg::fsw_write_t host_wr,
  // Status word, bits 6:0 read 0 here
  output logic [15:0] upper_status_word
);

  // ==========================================================
  // Parameter check
  generate
    if (SRC_W < 1) begin : g_bad_width
      $error("SRC_W must be at least 1");
    end
  endgenerate

  logic restart_event_indicator;
  logic [fsw_pkg::NUM_SOURCES-1:0] summary_n;
  logic frame_checksum_error_flag;
  logic frame_timeout_flag;
  logic serial_clock_count_error_flag;
  logic bad_address_access_flag;
  logic pend_checksum;
  logic pend_timeout;
  logic pend_sclk;
  logic pend_addr;
  logic bad_addr_now;
  logic sclk_wrong_now;
  logic restart_write;
  logic [3:0] frame_bits;

  // ==========================================================
  // Restart indicator
  assign restart_write = host_wr.en && host_wr.data[fsw_pkg::RESTART_BIT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      restart_event_indicator <= fsw_pkg::STATUS_RESET[fsw_pkg::RESTART_BIT];
    end else if (restart_write) begin
      restart_event_indicator <= 1'b1;
    end
  end

  // ==========================================================
  // Summary bits 14 down to 11
  genvar gi;
  generate
    for (gi = 0; gi < fsw_pkg::NUM_SOURCES; gi++) begin : g_sum
      fsw_summary_bit #(
        .SRC_W(SRC_W)
      ) u_sum (
        .clk_sys(clk_sys),
        .reset(reset),
        .src_flags(src_flags[gi]),
        .src_mask(src_mask[gi]),
        .write_one(host_wr.en && host_wr.data[fsw_pkg::POWER_BIT - gi]),
        .fault_n(summary_n[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Per-frame faults, collected now and reported in the next frame
  assign bad_addr_now = frame_evt.access && (frame_evt.access_addr >= fsw_pkg::FIRST_BAD_ADDR);
  assign sclk_wrong_now = frame_end && (sclk_count != sclk_required);

  // Events in the start cycle belong to the frame just opening
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_checksum <= 1'b0;
      pend_timeout <= 1'b0;
      pend_sclk <= 1'b0;
      pend_addr <= 1'b0;
    end else if (frame_start) begin
      pend_checksum <= frame_evt.checksum;
      pend_timeout <= frame_evt.timeout;
      pend_sclk <= sclk_wrong_now;
      pend_addr <= bad_addr_now;
    end else begin
      pend_checksum <= pend_checksum | frame_evt.checksum;
      pend_timeout <= pend_timeout | frame_evt.timeout;
      pend_sclk <= pend_sclk | sclk_wrong_now;
      pend_addr <= pend_addr | bad_addr_now;
    end
  end

  // Host writes never reach these bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_checksum_error_flag <= 1'b1;
      frame_timeout_flag <= 1'b1;
      serial_clock_count_error_flag <= 1'b1;
      bad_address_access_flag <= 1'b1;
    end else if (frame_start) begin
      frame_checksum_error_flag <= !pend_checksum;
      frame_timeout_flag <= !pend_timeout;
      serial_clock_count_error_flag <= !pend_sclk;
      bad_address_access_flag <= !pend_addr;
    end
  end

  assign upper_status_word = {
    restart_event_indicator,
    summary_n[0], summary_n[1], summary_n[2], summary_n[3],
    frame_checksum_error_flag,
    frame_timeout_flag,
    serial_clock_count_error_flag,
    bad_address_access_flag,
    fsw_pkg::STATUS_RESET[6:0]
  };

  assign frame_bits = upper_status_word[fsw_pkg::CHECKSUM_BIT:fsw_pkg::BAD_ADDR_BIT];

  // ==========================================================
  // Checks
  property p_reset_vals;
    @(posedge clk_sys) reset |=> (upper_status_word == fsw_pkg::STATUS_RESET);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_restart_hold;
    @(posedge clk_sys) disable iff (reset)
      (!upper_status_word[fsw_pkg::RESTART_BIT] && !restart_write)
        |=> !upper_status_word[fsw_pkg::RESTART_BIT];
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart flag lost");

  property p_restart_clear;
    @(posedge clk_sys) disable iff (reset)
      restart_write |=> upper_status_word[fsw_pkg::RESTART_BIT];
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart flag stuck");

  // Only a reset may bring the restart flag back to 0
  property p_restart_keep;
    @(posedge clk_sys) disable iff (reset)
      upper_status_word[fsw_pkg::RESTART_BIT] |=> upper_status_word[fsw_pkg::RESTART_BIT];
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart flag fell");

  // Each summary must land on its own bit of the word
  generate
    for (gi = 0; gi < fsw_pkg::NUM_SOURCES; gi++) begin : g_sum_chk
      property p_sum_map;
        @(posedge clk_sys) disable iff (reset)
          (|(src_flags[gi] & ~src_mask[gi])) |=> !upper_status_word[fsw_pkg::POWER_BIT - gi];
      endproperty
      a_sum_map: assert property (p_sum_map) else $error("bad summary");

      property p_sum_free;
        @(posedge clk_sys) disable iff (reset)
          (!(|(src_flags[gi] & ~src_mask[gi])) && host_wr.en
            && host_wr.data[fsw_pkg::POWER_BIT - gi])
            |=> upper_status_word[fsw_pkg::POWER_BIT - gi];
      endproperty
      a_sum_free: assert property (p_sum_free) else $error("summary not freed");
    end
  endgenerate

  // Per-frame bits move only at a frame start
  property p_frame_steady;
    @(posedge clk_sys) disable iff (reset)
      !frame_start |=> $stable(frame_bits);
  endproperty
  a_frame_steady: assert property (p_frame_steady) else $error("frame bits moved");

  sequence s_crc_caught;
    frame_evt.checksum && !frame_start;
  endsequence

  // Two quiet cycles, then the next frame opens
  sequence s_gap_to_start;
    (!frame_start)[*2] ##1 frame_start;
  endsequence

  property p_crc_report;
    @(posedge clk_sys) disable iff (reset)
      (s_crc_caught ##1 s_gap_to_start) |=> !upper_status_word[fsw_pkg::CHECKSUM_BIT];
  endproperty
  a_crc_report: assert property (p_crc_report) else $error("checksum fault missing");

  property p_timeout_report;
    @(posedge clk_sys) disable iff (reset)
      (pend_timeout && frame_start) |=> !upper_status_word[fsw_pkg::TIMEOUT_BIT];
  endproperty
  a_timeout_report: assert property (p_timeout_report) else $error("timeout missing");

  // The count is judged at frame end, one quiet cycle before the next start
  property p_sclk_report;
    @(posedge clk_sys) disable iff (reset)
      (sclk_wrong_now && !frame_start) ##1 !frame_start ##1 frame_start
        |=> !upper_status_word[fsw_pkg::SCLK_COUNT_BIT];
  endproperty
  a_sclk_report: assert property (p_sclk_report) else $error("clock count fault missing");

  property p_addr_report;
    @(posedge clk_sys) disable iff (reset)
      (frame_evt.access && (frame_evt.access_addr >= fsw_pkg::FIRST_BAD_ADDR) && !frame_start)
        ##1 s_gap_to_start
        |=> !upper_status_word[fsw_pkg::BAD_ADDR_BIT];
  endproperty
  a_addr_report: assert property (p_addr_report) else $error("bad address missing");

  // A legal address alone leaves the flag clear
  property p_addr_legal;
    @(posedge clk_sys) disable iff (reset)
      (frame_evt.access && (frame_evt.access_addr < fsw_pkg::FIRST_BAD_ADDR) && !frame_start
        && !pend_addr) ##1 ((!frame_start && !bad_addr_now)[*2] ##1 frame_start)
        |=> upper_status_word[fsw_pkg::BAD_ADDR_BIT];
  endproperty
  a_addr_legal: assert property (p_addr_legal) else $error("legal address flagged");

  property p_frame_clear;
    @(posedge clk_sys) disable iff (reset)
      (frame_start && !pend_checksum && !pend_timeout && !pend_sclk && !pend_addr)
        |=> (frame_bits == 4'hf);
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("frame bits not cleared");

  property p_read_only;
    @(posedge clk_sys) disable iff (reset)
      (host_wr.en && !frame_start) |=> $stable(frame_bits);
  endproperty
  a_read_only: assert property (p_read_only) else $error("host wrote frame bits");

endmodule

// ---- fsw_summary_bit.sv ----
// One sticky, active-low summary fault bit over a group of masked source flags
`timescale 1ns/1ns
module fsw_summary_bit #(
  parameter int SRC_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Source group, mask bit 1 hides its flag
  input wire logic [SRC_W-1:0] src_flags,
  input wire logic [SRC_W-1:0] src_mask,
  // Host wrote 1 to this bit
  input wire logic write_one,
  // Summary, 0 means fault
  output logic fault_n
);

  logic any_active;

  assign any_active = |(src_flags & ~src_mask);

  // A live fault wins over a host write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_n <= 1'b1;
    end else if (any_active) begin
      fault_n <= 1'b0;
    end else if (write_one) begin
      fault_n <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  property p_sum_low;
    @(posedge clk_sys) disable iff (reset)
      any_active |=> !fault_n;
  endproperty
  a_sum_low: assert property (p_sum_low) else $error("summary not low under fault");

  property p_sum_stay;
    @(posedge clk_sys) disable iff (reset)
      (!fault_n && !(write_one && !any_active)) |=> !fault_n;
  endproperty
  a_sum_stay: assert property (p_sum_stay) else $error("summary released early");

  property p_sum_restore;
    @(posedge clk_sys) disable iff (reset)
      (write_one && !any_active) |=> fault_n;
  endproperty
  a_sum_restore: assert property (p_sum_restore) else $error("summary not restored");

endmodule

// ---- tb_top.sv ----
// Testbench for the upper status word block
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] REQ = 8'h20;
  logic clk_sys;
  logic reset;
  logic [fsw_pkg::NUM_SOURCES-1:0][7:0] src_flags;
  logic [fsw_pkg::NUM_SOURCES-1:0][7:0] src_mask;
  logic frame_start;
  logic frame_end;
  logic [7:0] sclk_count;
  logic [7:0] sclk_required;
  fsw_pkg::fsw_frame_evt_t frame_evt;
  fsw_pkg::fsw_frame_evt_t evt;
  fsw_pkg::fsw_write_t host_wr;
  logic [15:0] upper_status_word;
  logic [15:0] w;
  logic [7:0] cnt;
  logic [15:0] exp_q[$];
  logic [31:0] rng;
  int err_count;
  int total_checks;
  fsw_host_model #(.REQ_SCLK(REQ)) host (.clk_sys(clk_sys), .frame_start(frame_start),
    .frame_end(frame_end), .sclk_count(sclk_count), .sclk_required(sclk_required),
    .frame_evt(frame_evt), .host_wr(host_wr));
  fsw_status_word #(.SRC_W(8)) DUT (.clk_sys(clk_sys), .reset(reset), .src_flags(src_flags),
    .src_mask(src_mask), .frame_start(frame_start), .frame_end(frame_end),
    .sclk_count(sclk_count), .sclk_required(sclk_required), .frame_evt(frame_evt),
    .host_wr(host_wr), .upper_status_word(upper_status_word));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value upper_status_word expected %h seen %h", e, s);
    end
  endtask
  // Note, then let the monitor sample two edges after the stimulus
  task automatic chk(input logic [15:0] e);
    host.tick();
    exp_q.push_back(e);
    host.tick();
    host.tick();
  endtask
  always @(posedge clk_sys) begin
    if (exp_q.size() > 0) begin
      #2;
      check_word(exp_q.pop_front(), upper_status_word);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end
  initial begin
    rng = 32'h499a396c;
    err_count = 0;
    total_checks = 0;
    reset = 1'b1;
    src_flags = '0;
    src_mask = '0;
    repeat (12) @(posedge clk_sys);
    #1 reset = 1'b0;
    chk(16'h7f80);
    host.write_word(16'h0000);
    chk(16'h7f80);
    host.write_word(16'h8000);
    chk(16'hff80);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      src_flags[i] = 8'h01 << rng[2:0];
      src_mask[i] = src_flags[i];
      chk(16'hff80);
      src_mask[i] = ~src_flags[i];
      w = 16'hff80 & ~(16'h4000 >> i);
      chk(w);
      host.write_word(16'hffff);
      chk(w);
      // Host clears its source flags before the write of 1
      src_flags[i] = '0;
      chk(w);
      host.write_word(16'h4000 >> i);
      chk(16'hff80);
      src_mask[i] = rng[15:8];
    end
    for (int k = 0; k < 6; k++) begin
      evt = '0;
      cnt = REQ;
      w = 16'hff80;
      case (k)
        0: begin
          evt.checksum = 1'b1;
          w = 16'hfb80;
        end
        1: begin
          evt.timeout = 1'b1;
          w = 16'hfd80;
        end
        2: begin
          cnt = REQ - 8'h01;
          w = 16'hfe80;
        end
        3: begin
          cnt = REQ + 8'h01;
          w = 16'hfe80;
        end
        4: begin
          evt.access = 1'b1;
          evt.access_addr = 8'hff;
          w = 16'hff00;
        end
        default: begin
          evt.access = 1'b1;
          evt.access_addr = 8'hfe;
        end
      endcase
      host.frame(evt, cnt);
      host.frame('0, REQ);
      chk(w);
      host.write_word(16'hffff);
      chk(w);
      host.frame('0, REQ);
      chk(16'hff80);
    end
    reset = 1'b1;
    host.tick();
    host.tick();
    reset = 1'b0;
    chk(16'h7f80);
    print_verdict();
  end
endmodule
